// ===== verilog/pmcd_pkg.sv
/*
 * pmcd_pkg: register map, field layout, reset values and shared types of the
 * power mode and clock divider block.
 * assumes: a single 200 MHz hclk domain; registers are reached over AHB-Lite.
 */
package pmcd_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] PMCD_MAP_OFS    = 12'h000;
	localparam logic [11:0] PMCD_PWR_OFS    = 12'h004;
	localparam logic [11:0] PMCD_PERIPH_OFS = 12'h008;
	localparam logic [11:0] PMCD_DIV_OFS    = 12'h00C;
	localparam logic [11:0] PMCD_STAT_OFS   = 12'h010;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int          PMCD_PWR_IDLE_BIT = 0;
	localparam int          PMCD_PWR_PD_BIT   = 1;
	localparam int          PMCD_RTC_EXT_BIT  = 2;
	localparam int          PMCD_NPERIPH      = 16;
	localparam logic [1:0]  PMCD_MAP_FLASH    = 2'h0;
	localparam logic [1:0]  PMCD_MAP_SRAM     = 2'h1;
	localparam logic [1:0]  PMCD_DIV_QUARTER  = 2'h0;
	localparam logic [1:0]  PMCD_DIV_FULL     = 2'h1;
	localparam logic [1:0]  PMCD_DIV_HALF     = 2'h2;
	localparam logic [15:0] PMCD_PERIPH_RST   = 16'hFFFF;
	localparam logic [1:0]  PMCD_HTRANS_NONSEQ = 2'h2;

	// debug host must keep the test clock below cpu_clock / this figure
	localparam int          PMCD_JTAG_DIV_MIN = 6;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PMCD_RUN  = 3'b001,
		PMCD_IDLE = 3'b010,
		PMCD_PD   = 3'b100
	} pmcd_mode_t;

	typedef struct packed {
		logic        cpu_clk_en;
		logic        pclk_en;
		logic        osc_en;
		logic        pll_keep;
		logic        rtc_clk_en;
		logic        hold_pins;
	} pmcd_clkctl_t;

endpackage : pmcd_pkg

// ===== verilog/pmcd_top.sv
/*
 * pmcd_top: vector remap select, idle and power-down sequencing, per
 * peripheral clock enables and the cpu_clock to peripheral clock divider.
 * assumes: AHB-Lite single word transfers; wake inputs are asynchronous
 * pins and pass a three-stage synchroniser; the clock gates sit outside.
 */
`timescale 1ns/100ps

// Summary of operation
// - software selects flash or sram to serve the vector area at zero.
// - idle stops cpu execution until a reset or an interrupt arrives.
// - peripheral clocks keep running during idle so interrupts can wake.
// - power-down stops the oscillator and withholds every internal clock.
// - power-down keeps register, sram contents and holds output pins static.
// - power-down ends on reset or on a clockless wake interrupt.
// - rtc on external low-frequency clock keeps running in power-down.
// - each peripheral has its own clock enable in active and idle.
// - peripheral clock is cpu_clock divided by one, two or four.
// - after reset the peripheral clock divider selects one quarter.
// - a running pll stays active during idle mode.
// - divider register sits on the peripheral bus, running at reset divider; here it sits on the ahb-lite slave at undivided hclk.
module pmcd_top
	import pmcd_pkg::*;
(
	// bus clock and reset
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	// ahb-lite slave
	input  wire logic                     hsel,
	input  wire logic [11:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic      [31:0]              hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	// wake sources
	input  wire logic                     irq_any,
	input  wire logic                     wake_irq,
	// clock control outputs
	output logic                          vec_sram,
	output pmcd_pkg::pmcd_clkctl_t        clkctl,
	output logic [pmcd_pkg::PMCD_NPERIPH-1:0] periph_clk_en,
	output logic                          pclk_tick
);
	import pmcd_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] div_limit(input logic [1:0] sel);
		case (sel)
			PMCD_DIV_FULL: div_limit = 2'h0;
			PMCD_DIV_HALF: div_limit = 2'h1;
			default:       div_limit = 2'h3;
		endcase
	endfunction : div_limit

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic        wr_pend_reg;
	logic [11:0] addr_reg;
	logic [1:0]  map_reg;
	logic [2:0]  pwr_reg;
	logic [15:0] periph_reg;
	logic [1:0]  div_reg;
	logic        wake_seen_reg;
	logic        wake_evt;
	pmcd_mode_t  mode_reg;
	logic        take;

	assign take = hsel && hready && (htrans == PMCD_HTRANS_NONSEQ);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg    <= 12'h000;
		end else begin
			wr_pend_reg <= take && hwrite;
			if (take)
				addr_reg <= haddr;
		end
	end

	// zero wait state, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// read data registered from the address phase; unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			case (haddr)
				PMCD_MAP_OFS:    hrdata <= {30'h0, map_reg};
				PMCD_PWR_OFS:    hrdata <= {29'h0, pwr_reg};
				PMCD_PERIPH_OFS: hrdata <= {16'h0, periph_reg};
				PMCD_DIV_OFS:    hrdata <= {30'h0, div_reg};
				PMCD_STAT_OFS:   hrdata <= {28'h0, wake_seen_reg, mode_reg};
				default:         hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			map_reg    <= PMCD_MAP_FLASH;
			periph_reg <= PMCD_PERIPH_RST;
			div_reg    <= PMCD_DIV_QUARTER;
		end else if (wr_pend_reg) begin
			case (addr_reg)
				PMCD_MAP_OFS:    map_reg    <= hwdata[1:0];
				PMCD_PERIPH_OFS: periph_reg <= hwdata[15:0];
				// reachable at the reset divider: the bus timing here never changes
				PMCD_DIV_OFS:    div_reg    <= hwdata[1:0];
				default: ;
			endcase
		end
	end

	// the mode bits clear on wake; a wake in the write cycle still wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_reg <= 3'h0;
		end else if (wake_evt) begin
			pwr_reg[PMCD_PWR_IDLE_BIT] <= 1'b0;
			pwr_reg[PMCD_PWR_PD_BIT]   <= 1'b0;
		end else if (wr_pend_reg && addr_reg == PMCD_PWR_OFS) begin
			pwr_reg <= hwdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// wake synchronisers
	// ----------------------------------------------------------------
	logic [2:0] irq_sync_reg;
	logic [2:0] wake_sync_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_sync_reg  <= 3'h0;
			wake_sync_reg <= 3'h0;
		end else begin
			irq_sync_reg  <= {irq_sync_reg[1:0], irq_any};
			wake_sync_reg <= {wake_sync_reg[1:0], wake_irq};
		end
	end

	logic irq_ok;
	logic wake_ok;
	assign irq_ok  = irq_sync_reg[1] && irq_sync_reg[2];
	assign wake_ok = wake_sync_reg[1] && wake_sync_reg[2];

	// ----------------------------------------------------------------
	// mode sequencer
	// ----------------------------------------------------------------
	pmcd_mode_t mode_next;

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			PMCD_RUN: begin
				if (pwr_reg[PMCD_PWR_PD_BIT])
					mode_next = PMCD_PD;
				else if (pwr_reg[PMCD_PWR_IDLE_BIT])
					mode_next = PMCD_IDLE;
			end
			PMCD_IDLE: begin
				if (irq_ok)
					mode_next = PMCD_RUN;
			end
			PMCD_PD: begin
				// only the clockless wake line ends power-down
				if (wake_ok)
					mode_next = PMCD_RUN;
			end
			default: mode_next = PMCD_RUN;
		endcase
	end

	assign wake_evt = (mode_reg != PMCD_RUN) && (mode_next == PMCD_RUN);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mode_reg <= PMCD_RUN;
		else
			mode_reg <= mode_next;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wake_seen_reg <= 1'b0;
		else if (wake_evt)
			wake_seen_reg <= 1'b1;
		else if (wr_pend_reg && addr_reg == PMCD_STAT_OFS)
			wake_seen_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// clock control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clkctl        <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			periph_clk_en <= PMCD_PERIPH_RST;
			vec_sram      <= 1'b0;
		end else begin
			vec_sram           <= (map_reg == PMCD_MAP_SRAM);
			clkctl.cpu_clk_en  <= (mode_next == PMCD_RUN);
			clkctl.pclk_en     <= (mode_next != PMCD_PD);
			clkctl.osc_en      <= (mode_next != PMCD_PD);
			clkctl.pll_keep    <= (mode_next != PMCD_PD);
			// rtc clock survives power-down only on the external source
			clkctl.rtc_clk_en  <= (mode_next != PMCD_PD) || pwr_reg[PMCD_RTC_EXT_BIT];
			// pin and state retention: outputs freeze, nothing is reset
			clkctl.hold_pins   <= (mode_next == PMCD_PD);
			periph_clk_en      <= (mode_next == PMCD_PD) ? 16'h0000 : periph_reg;
		end
	end

	// ----------------------------------------------------------------
	// peripheral clock divider
	// ----------------------------------------------------------------
	logic [1:0] div_cnt_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_reg <= 2'h0;
			pclk_tick   <= 1'b0;
		end else if (div_cnt_reg >= div_limit(div_reg)) begin
			div_cnt_reg <= 2'h0;
			pclk_tick   <= (mode_next != PMCD_PD);
		end else begin
			div_cnt_reg <= div_cnt_reg + 2'h1;
			pclk_tick   <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	map_follow_a: assert property (wr_pend_reg && addr_reg == PMCD_MAP_OFS
		|=> ##1 vec_sram == (map_reg == PMCD_MAP_SRAM))
		else $error("vector remap does not follow the map register");
	idle_wake_a: assert property (mode_reg == PMCD_IDLE && irq_ok
		|=> mode_reg == PMCD_RUN && clkctl.cpu_clk_en)
		else $error("idle did not end on interrupt");
	idle_pclk_a: assert property (mode_reg == PMCD_IDLE
		|-> clkctl.pclk_en && !clkctl.cpu_clk_en)
		else $error("idle clock gating wrong");
	pd_clocks_a: assert property (mode_reg == PMCD_PD
		|-> !clkctl.osc_en && !clkctl.pclk_en && periph_clk_en == 16'h0000)
		else $error("clock running in power-down");
	pd_hold_a: assert property (mode_reg == PMCD_PD |-> clkctl.hold_pins)
		else $error("pins not held in power-down");
	hold_run_a: assert property (mode_reg == PMCD_RUN |-> !clkctl.hold_pins)
		else $error("pins held while running");
	pd_wake_a: assert property (mode_reg == PMCD_PD && !wake_ok |=> mode_reg == PMCD_PD)
		else $error("power-down left without wake");
	rtc_ext_a: assert property (mode_reg == PMCD_PD
		|-> clkctl.rtc_clk_en == pwr_reg[PMCD_RTC_EXT_BIT])
		else $error("rtc clock wrong in power-down");
	periph_follow_a: assert property (mode_reg != PMCD_PD && $stable(periph_reg)
		|-> periph_clk_en == periph_reg)
		else $error("peripheral clock enables do not follow the register");
	div_quarter_a: assert property (div_reg == PMCD_DIV_QUARTER && mode_reg == PMCD_RUN
		&& $stable(div_reg) && pclk_tick |=> !pclk_tick [*3])
		else $error("quarter divider ticks too often");
	// at full rate every edge ticks, unless the next mode is power-down (entering or staying)
	div_full_a: assert property (div_reg == PMCD_DIV_FULL && mode_next != PMCD_PD
		|=> pclk_tick)
		else $error("full rate divider skipped a tick");
	div_reset_a: assert property ($rose(hresetn) |-> div_reg == PMCD_DIV_QUARTER)
		else $error("divider not at quarter after reset");
	pll_idle_a: assert property (mode_reg == PMCD_IDLE |-> clkctl.pll_keep)
		else $error("pll dropped in idle");
	auto_clear_a: assert property (wake_evt |=> pwr_reg[1:0] == 2'h0)
		else $error("mode bits not cleared on wake");

	idle_cycle_c: cover property (mode_reg == PMCD_IDLE ##[1:50] mode_reg == PMCD_RUN);
	pd_cycle_c:   cover property (mode_reg == PMCD_PD ##[1:50] mode_reg == PMCD_RUN);
	half_div_c:   cover property (div_reg == PMCD_DIV_HALF && pclk_tick);
	sram_map_c:   cover property (vec_sram);
	rtc_pd_c:     cover property (mode_reg == PMCD_PD && clkctl.rtc_clk_en);

endmodule : pmcd_top

// ===== bench/pmcd_partner.sv
/*
 * pmcd_partner: core and peripheral side that receives the gated clocks.
 * assumes: one hclk; wake lines are plain levels with no pull.
 */
`timescale 1ns/100ps

module pmcd_partner
	import pmcd_pkg::*;
(
	// clock
	input  wire logic          hclk,
	// clock control seen from the block
	input  wire pmcd_pkg::pmcd_clkctl_t clkctl,
	input  wire logic          pclk_tick,
	// wake requests back to the block
	output logic               irq_any,
	output logic               wake_irq,
	// measured peripheral clock period in hclk cycles
	output logic [3:0]         tick_gap,
	// debug host test clock
	output logic               tck
);
	logic [3:0] cnt;
	logic [3:0] jcnt;

	initial begin
		irq_any  = 1'b0;
		wake_irq = 1'b0;
		cnt      = 4'h0;
		tick_gap = 4'h0;
		tck      = 1'b0;
		jcnt     = 4'h0;
	end

	// debug host: each test clock half period spans the floor in cpu cycles,
	// so the full rate stays well under one sixth of cpu_clock
	always @(posedge hclk) begin
		if (clkctl.cpu_clk_en === 1'b1) begin
			jcnt <= (jcnt == 4'(PMCD_JTAG_DIV_MIN - 1)) ? 4'h0 : jcnt + 4'h1;
			if (jcnt == 4'(PMCD_JTAG_DIV_MIN - 1))
				tck <= ~tck;
		end
	end

	// a peripheral counts hclk between ticks; keeps counting while ticks are withheld
	always @(posedge hclk) begin
		cnt <= pclk_tick ? 4'h0 : cnt + 4'h1;
		if (pclk_tick)
			tick_gap <= cnt + 4'h1;
	end

	// held five cycles so the three stage synchroniser sees it; clockless kind for pd
	task pulse(input logic pd);
		@(posedge hclk);
		if (pd) wake_irq <= 1'b1;
		else irq_any <= 1'b1;
		repeat (5) @(posedge hclk);
		irq_any  <= 1'b0;
		wake_irq <= 1'b0;
	endtask : pulse
endmodule : pmcd_partner

// ===== bench/pmcd_top_tb.sv
/*
 * pmcd_top_tb: scenario tasks over ahb-lite for remap, divider, gating, modes.
 * assumes: hready tied to hreadyout; partner drives the wake lines.
 */
`timescale 1ns/100ps

module pmcd_top_tb;
	import pmcd_pkg::*;
	logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [11:0]  haddr;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic [31:0]  hwdata, hrdata, rd;
	logic         irq_any, wake_irq, vec_sram, pclk_tick;
	logic [15:0]  periph_clk_en;
	logic [3:0]   tick_gap;
	logic         tck;
	pmcd_clkctl_t clkctl;
	int           fail_count, num_checks, cyc;

	pmcd_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq_any(irq_any), .wake_irq(wake_irq), .vec_sram(vec_sram),
		.clkctl(clkctl), .periph_clk_en(periph_clk_en), .pclk_tick(pclk_tick));
	pmcd_partner u_far (.hclk(hclk), .clkctl(clkctl), .pclk_tick(pclk_tick),
		.irq_any(irq_any), .wake_irq(wake_irq), .tick_gap(tick_gap), .tck(tck));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc > 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// one single word transfer; waits on hready in both phases
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= PMCD_HTRANS_NONSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : bus

	task wait_cpu;
		for (int i = 0; i < 12 && clkctl.cpu_clk_en !== 1'b1; i++) @(posedge hclk);
	endtask : wait_cpu

	task t_reset;
		chk("vec", 32'h0, {31'h0, vec_sram});
		chk("clkctl", 32'h3E, {26'h0, clkctl});
		chk("periph", 32'hFFFF, {16'h0, periph_clk_en});
		bus(1'b0, PMCD_DIV_OFS, 32'h0);
		chk("div", 32'h0, rd);
		repeat (12) @(posedge hclk);
		chk("gap", 32'h4, {28'h0, tick_gap});
		bus(1'b0, 12'h040, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("reset done");
	endtask : t_reset

	task t_remap;
		bus(1'b1, PMCD_MAP_OFS, {30'h0, PMCD_MAP_SRAM});
		repeat (2) @(posedge hclk);
		chk("vec", 32'h1, {31'h0, vec_sram});
		bus(1'b0, PMCD_MAP_OFS, 32'h0);
		chk("map rd", 32'h1, rd);
		bus(1'b1, PMCD_MAP_OFS, {30'h0, PMCD_MAP_FLASH});
		repeat (2) @(posedge hclk);
		chk("vec", 32'h0, {31'h0, vec_sram});
		$display("remap done");
	endtask : t_remap

	task t_div;
		logic [3:0] exp [4];
		exp = '{4'h1, 4'h2, 4'h4, 4'h4};
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, PMCD_DIV_OFS, 32'(i + 1) & 32'h3);
			repeat (12) @(posedge hclk);
			chk("gap", {28'h0, exp[i]}, {28'h0, tick_gap});
		end
		$display("div done");
	endtask : t_div

	task t_idle;
		bus(1'b1, PMCD_PERIPH_OFS, 32'hA5A5);
		bus(1'b1, PMCD_PWR_OFS, 32'h1);
		repeat (3) @(posedge hclk);
		chk("periph", 32'hA5A5, {16'h0, periph_clk_en});
		chk("idle ctl", 32'h1C, {26'h0, clkctl & 6'h3D});
		bus(1'b0, PMCD_STAT_OFS, 32'h0);
		chk("stat", 32'h2, rd & 32'h7);
		u_far.pulse(1'b1);
		chk("stay idle", 32'h0, {31'h0, clkctl.cpu_clk_en});
		u_far.pulse(1'b0);
		wait_cpu();
		chk("woke", 32'h1, {31'h0, clkctl.cpu_clk_en});
		bus(1'b0, PMCD_PWR_OFS, 32'h0);
		chk("pwr", 32'h0, rd & 32'h3);
		$display("idle done");
	endtask : t_idle

	task t_pd;
		bus(1'b1, PMCD_PWR_OFS, 32'h6);
		repeat (3) @(posedge hclk);
		chk("pd ctl", 32'h03, {26'h0, clkctl & 6'h3B});
		chk("periph", 32'h0, {16'h0, periph_clk_en});
		u_far.pulse(1'b0);
		chk("tick", 32'h0, {31'h0, pclk_tick});
		chk("stay pd", 32'h0, {31'h0, clkctl.cpu_clk_en});
		u_far.pulse(1'b1);
		wait_cpu();
		chk("woke", 32'h1, {31'h0, clkctl.cpu_clk_en});
		chk("periph", 32'hA5A5, {16'h0, periph_clk_en});
		bus(1'b0, PMCD_STAT_OFS, 32'h0);
		chk("stat", 32'h9, rd & 32'hF);
		bus(1'b1, PMCD_STAT_OFS, 32'h0);
		bus(1'b0, PMCD_STAT_OFS, 32'h0);
		chk("stat clr", 32'h1, rd & 32'hF);
		bus(1'b0, PMCD_PWR_OFS, 32'h0);
		chk("pwr", 32'h4, rd & 32'h7);
		$display("pd done");
	endtask : t_pd

	task t_jtag;
		int n;
		n = 0;
		@(posedge tck);
		while (tck === 1'b1) begin
			@(posedge hclk);
			n++;
		end
		chk("tck period", 32'h1, {31'h0, (2 * n) > PMCD_JTAG_DIV_MIN});
		$display("jtag done");
	endtask : t_jtag

	task t_rerst;
		bus(1'b1, PMCD_DIV_OFS, {30'h0, PMCD_DIV_HALF});
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, PMCD_DIV_OFS, 32'h0);
		chk("div", 32'h0, rd);
		repeat (12) @(posedge hclk);
		chk("gap", 32'h4, {28'h0, tick_gap});
		$display("rerst done");
	endtask : t_rerst

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 12'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		fail_count = 0;
		num_checks = 0;
		cyc = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_jtag();
		t_remap();
		t_div();
		t_idle();
		t_pd();
		t_rerst();
		report_and_stop();
	end
endmodule : pmcd_top_tb
